// ### hw/tcw_pkg.sv
// Constants, register map and mode decoding types for the compare timer
// How it works
// - Synchronous logic, tick acts as enable
// - Dual-slope modes 8, 9 load compares at BOTTOM
// - BOTTOM events use TOP-case timing, renamed
// - Nonzero action field hands pin to output
// - Non-PWM match: off, toggle, low, high
// - Fast toggle only channel A, modes 14/15
// - Fast codes 10/11: non-inverting, inverting
// - Fast codes 10/11: compare equal TOP ignores match
// - Dual toggle only channel A, modes 9/11
// - Dual: clear up, set down, or reverse
// - Mode joins two low and two high bits
// - Control A: actions 7:6, 5:4, mode 1:0
// - Modes 8 and 9 are dual-slope PFC
// - Tick select: stop, prescales, external edges
// - Force strobes: non-PWM only, read zero
package tcw_pkg;
   localparam logic [7:0] OFS_CTRL_A = 8'h80;
   localparam logic [7:0] OFS_CTRL_B = 8'h81;
   localparam logic [7:0] OFS_CTRL_C = 8'h82;
   localparam logic [7:0] OFS_CNT_LO = 8'h84;
   localparam logic [7:0] OFS_CNT_HI = 8'h85;
   localparam logic [7:0] OFS_CAP_LO = 8'h86;
   localparam logic [7:0] OFS_CAP_HI = 8'h87;
   localparam logic [7:0] OFS_CMPA_LO = 8'h88;
   localparam logic [7:0] OFS_CMPA_HI = 8'h89;
   localparam logic [7:0] OFS_CMPB_LO = 8'h8A;
   localparam logic [7:0] OFS_CMPB_HI = 8'h8B;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h8C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h8D;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] CTRL_A_MASK = 8'hF3;
   localparam logic [7:0] CTRL_B_MASK = 8'hDF;
   localparam int ACT_A_POS = 6;
   localparam int ACT_B_POS = 4;
   localparam int MODE_LO_POS = 0;
   localparam int MODE_HI_POS = 3;
   localparam int SEL_POS = 0;
   localparam int FORCE_A_POS = 7;
   localparam int FORCE_B_POS = 6;
   localparam int ST_WRAP = 0;
   localparam int ST_MATCH_A = 1;
   localparam int ST_MATCH_B = 2;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [9:0] PRE_8 = 10'h007;
   localparam logic [9:0] PRE_64 = 10'h03F;
   localparam logic [9:0] PRE_256 = 10'h0FF;
   localparam logic [9:0] PRE_1024 = 10'h3FF;
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_LOW = 2'h2;
   localparam logic [1:0] ACT_HIGH = 2'h3;

   // Waveform family of the selected mode
   typedef enum logic [2:0] {
      KIND_NONPWM = 3'h1,
      KIND_FAST = 3'h2,
      KIND_DUAL = 3'h4
   } tcw_kind_type;

   // Tick source select codes
   typedef enum logic [2:0] {
      SEL_STOP = 3'h0,
      SEL_DIV1 = 3'h1,
      SEL_DIV8 = 3'h2,
      SEL_DIV64 = 3'h3,
      SEL_DIV256 = 3'h4,
      SEL_DIV1024 = 3'h5,
      SEL_EXT_FALL = 3'h6,
      SEL_EXT_RISE = 3'h7
   } tcw_sel_type;
endpackage : tcw_pkg

// ### hw/tcw_timer16.sv
// Top level of the 16-bit compare timer with two waveform channels
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module tcw_timer16 (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic ext_tick_in,
   output logic cmp_out_a_out,
   output logic cmp_out_b_out,
   output logic cmp_out_a_en_out,
   output logic cmp_out_b_en_out,
   output logic irq_out
);
   import tcw_pkg::*;

   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [15:0] count;
   logic count_up;
   logic [15:0] capture_top_value;
   logic [15:0] cmp_buf [2];
   logic [15:0] cmp_act [2];
   logic [1:0] cmp_out;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [9:0] presc;
   logic ext_prev;

   // Mode assembly from both control registers
   logic [3:0] wave_mode_sel;
   logic [1:0] chan_a_out_action;
   logic [1:0] chan_b_out_action;
   logic [2:0] tick_source_sel;
   assign wave_mode_sel = {ctrl_b[MODE_HI_POS+1:MODE_HI_POS],
                           ctrl_a[MODE_LO_POS+1:MODE_LO_POS]};
   assign chan_a_out_action = ctrl_a[ACT_A_POS+1:ACT_A_POS];
   assign chan_b_out_action = ctrl_a[ACT_B_POS+1:ACT_B_POS];
   assign tick_source_sel = ctrl_b[SEL_POS+2:SEL_POS];

   // Family of each waveform mode; reserved mode 13 counts as normal
   function automatic tcw_kind_type kind_of(input logic [3:0] m);
      tcw_kind_type k;
      k = KIND_NONPWM;
      if (m == 4'h5 || m == 4'h6 || m == 4'h7 || m == 4'hE || m == 4'hF) begin
         k = KIND_FAST;
      end else if (m == 4'h1 || m == 4'h2 || m == 4'h3 || m == 4'h8 ||
                   m == 4'h9 || m == 4'hA || m == 4'hB) begin
         k = KIND_DUAL;
      end
      return k;
   endfunction : kind_of

   // TOP source of each waveform mode
   function automatic logic [15:0] top_of(input logic [3:0] m,
                                          input logic [15:0] cap,
                                          input logic [15:0] cmpa);
      logic [15:0] t;
      t = CNT_MAX;
      unique case (m)
         4'h1, 4'h5: t = TOP_8BIT;
         4'h2, 4'h6: t = TOP_9BIT;
         4'h3, 4'h7: t = TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: t = cmpa;
         4'h8, 4'hA, 4'hC, 4'hE: t = cap;
         4'h0, 4'hD: t = CNT_MAX;
      endcase
      return t;
   endfunction : top_of

   tcw_kind_type kind;
   logic [15:0] top;
   assign kind = kind_of(wave_mode_sel);
   assign top = top_of(wave_mode_sel, capture_top_value, cmp_act[0]);

   // Tick enable; the prescaler runs free, so the first divided tick
   // after a select change may come early
   logic tick;
   logic ext_fall;
   logic ext_rise;
   assign ext_fall = ext_prev & ~ext_tick_in;
   assign ext_rise = ~ext_prev & ext_tick_in;
   always_comb begin
      tick = 1'b0;
      unique case (tcw_sel_type'(tick_source_sel))
         SEL_STOP: tick = 1'b0;
         SEL_DIV1: tick = 1'b1;
         SEL_DIV8: tick = (presc[2:0] == PRE_8[2:0]);
         SEL_DIV64: tick = (presc[5:0] == PRE_64[5:0]);
         SEL_DIV256: tick = (presc[7:0] == PRE_256[7:0]);
         SEL_DIV1024: tick = (presc == PRE_1024);
         SEL_EXT_FALL: tick = ext_fall;
         SEL_EXT_RISE: tick = ext_rise;
      endcase
   end

   // Count events, qualified by the tick enable except the non-PWM compare load
   logic at_top;
   logic at_bottom;
   logic dual_top;
   logic dual_bottom;
   logic fast_wrap;
   logic wrap_flag;
   logic load_cmp;
   assign at_top = tick & (count == top);
   assign at_bottom = tick & (count == CNT_BOTTOM) & ~count_up;
   assign dual_top = (kind == KIND_DUAL) & at_top & count_up;
   assign dual_bottom = (kind == KIND_DUAL) & at_bottom;
   assign fast_wrap = (kind == KIND_FAST) & at_top;
   assign wrap_flag = ((kind == KIND_NONPWM) & tick & (count == CNT_MAX)) |
                      fast_wrap | dual_bottom;
   // Buffered compare transfer point per mode
   assign load_cmp = (kind == KIND_NONPWM) | fast_wrap |
                     (dual_bottom & (wave_mode_sel[3:1] == 3'h4)) |
                     (dual_top & (wave_mode_sel[3:1] != 3'h4));

   // Next counter value and direction
   logic [15:0] next_count;
   logic next_count_up;
   always_comb begin
      next_count = count;
      next_count_up = count_up;
      if (tick && kind == KIND_DUAL) begin
         if (count_up && count >= top) begin
            next_count_up = 1'b0;
            next_count = count - 16'h0001;
         end else if (!count_up && count == CNT_BOTTOM) begin
            next_count_up = 1'b1;
            next_count = count + 16'h0001;
         end else begin
            next_count = count_up ? count + 16'h0001 : count - 16'h0001;
         end
      end else if (tick) begin
         next_count_up = 1'b1;
         next_count = at_top ? CNT_BOTTOM : count + 16'h0001;
      end
   end

   // Register decode
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_ctrl_c;
   logic wr_stat;
   logic [1:0] force_cmp;
   assign wr_ctrl_a = reg_wr_in & (reg_addr_in == OFS_CTRL_A);
   assign wr_ctrl_b = reg_wr_in & (reg_addr_in == OFS_CTRL_B);
   assign wr_ctrl_c = reg_wr_in & (reg_addr_in == OFS_CTRL_C);
   assign wr_stat = reg_wr_in & (reg_addr_in == OFS_IRQ_STAT);
   assign force_cmp = {2{wr_ctrl_c & (kind == KIND_NONPWM)}} &
                      {reg_wdata_in[FORCE_B_POS],
                       reg_wdata_in[FORCE_A_POS]};

   // Next output level of one channel for its action field
   function automatic logic chan_next(input logic cur,
                                      input logic [1:0] act,
                                      input tcw_kind_type k,
                                      input logic toggle_ok,
                                      input logic up,
                                      input logic match,
                                      input logic bottom);
      logic v;
      v = cur;
      unique case (k)
         KIND_NONPWM: begin
            if (match && act == ACT_TOGGLE) v = ~cur;
            if (match && act == ACT_LOW) v = 1'b0;
            if (match && act == ACT_HIGH) v = 1'b1;
         end
         KIND_FAST: begin
            if (act[1] && bottom) v = ~act[0];
            if (act[1] && match) v = act[0];
            if (act == ACT_TOGGLE && toggle_ok && match) v = ~cur;
         end
         KIND_DUAL: begin
            if (act[1] && match) v = up ? act[0] : ~act[0];
            if (act == ACT_TOGGLE && toggle_ok && match) v = ~cur;
         end
      endcase
      return v;
   endfunction : chan_next

   // Per-channel compare, match flag and output
   logic [1:0] tick_match;
   logic [1:0] next_out;
   logic [1:0] chan_en;
   logic [1:0] act_sel [2];
   logic [1:0] toggle_ok;
   assign act_sel[0] = chan_a_out_action;
   assign act_sel[1] = chan_b_out_action;
   // Only channel A may toggle in PWM modes, as B would lack a TOP
   assign toggle_ok[0] = (kind == KIND_FAST) ?
                         (wave_mode_sel == 4'hE || wave_mode_sel == 4'hF) :
                         (wave_mode_sel == 4'h9 || wave_mode_sel == 4'hB);
   assign toggle_ok[1] = 1'b0;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic ignore;
         logic eff_match;
         assign tick_match[ch] = tick & (count == cmp_act[ch]);
         assign ignore = (kind == KIND_FAST) & act_sel[ch][1] &
                         (cmp_act[ch] == top);
         assign eff_match = (tick_match[ch] & ~ignore) | force_cmp[ch];
         assign next_out[ch] = chan_next(cmp_out[ch], act_sel[ch], kind,
                                         toggle_ok[ch], count_up,
                                         eff_match, fast_wrap);
         assign chan_en[ch] = |act_sel[ch];
      end
   endgenerate

   // Interrupt status: set wins over a write-one clear
   logic [2:0] irq_set;
   logic [2:0] next_stat;
   assign irq_set = {tick_match[1], tick_match[0], wrap_flag};
   assign next_stat = (irq_stat & ~({3{wr_stat}} & reg_wdata_in[2:0])) |
                      irq_set;

   // Control and interrupt registers
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_a <= REG_RESET;
         ctrl_b <= REG_RESET;
         irq_mask <= REG_RESET[2:0];
         irq_stat <= REG_RESET[2:0];
      end else begin
         if (wr_ctrl_a) ctrl_a <= reg_wdata_in & CTRL_A_MASK;
         if (wr_ctrl_b) ctrl_b <= reg_wdata_in & CTRL_B_MASK;
         if (reg_wr_in && reg_addr_in == OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata_in[2:0];
         end
         irq_stat <= next_stat;
      end
   end

   // Compare buffers, top capture word and active compares
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         capture_top_value <= WORD_RESET;
         cmp_buf[0] <= WORD_RESET;
         cmp_buf[1] <= WORD_RESET;
         cmp_act[0] <= WORD_RESET;
         cmp_act[1] <= WORD_RESET;
      end else begin
         if (reg_wr_in) begin
            unique case (reg_addr_in)
               OFS_CAP_LO: capture_top_value[7:0] <= reg_wdata_in;
               OFS_CAP_HI: capture_top_value[15:8] <= reg_wdata_in;
               OFS_CMPA_LO: cmp_buf[0][7:0] <= reg_wdata_in;
               OFS_CMPA_HI: cmp_buf[0][15:8] <= reg_wdata_in;
               OFS_CMPB_LO: cmp_buf[1][7:0] <= reg_wdata_in;
               OFS_CMPB_HI: cmp_buf[1][15:8] <= reg_wdata_in;
               default: ;
            endcase
         end
         if (load_cmp) begin
            cmp_act[0] <= cmp_buf[0];
            cmp_act[1] <= cmp_buf[1];
         end
      end
   end

   // Counter, prescaler and channel outputs
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count <= WORD_RESET;
         count_up <= 1'b1;
         presc <= 10'h000;
         ext_prev <= 1'b0;
         cmp_out <= 2'h0;
      end else begin
         count <= next_count;
         count_up <= next_count_up;
         presc <= presc + 10'h001;
         ext_prev <= ext_tick_in;
         cmp_out <= next_out;
      end
   end

   // Read mux; force strobes and unmapped addresses read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr_in)
         OFS_CTRL_A: rd_mux = ctrl_a;
         OFS_CTRL_B: rd_mux = ctrl_b;
         OFS_CTRL_C: rd_mux = 8'h00;
         OFS_CNT_LO: rd_mux = count[7:0];
         OFS_CNT_HI: rd_mux = count[15:8];
         OFS_CAP_LO: rd_mux = capture_top_value[7:0];
         OFS_CAP_HI: rd_mux = capture_top_value[15:8];
         OFS_CMPA_LO: rd_mux = cmp_buf[0][7:0];
         OFS_CMPA_HI: rd_mux = cmp_buf[0][15:8];
         OFS_CMPB_LO: rd_mux = cmp_buf[1][7:0];
         OFS_CMPB_HI: rd_mux = cmp_buf[1][15:8];
         OFS_IRQ_STAT: rd_mux = {5'h00, irq_stat};
         OFS_IRQ_MASK: rd_mux = {5'h00, irq_mask};
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
      end
   end

   // Pin drive; the port direction bit outside still gates the driver
   assign cmp_out_a_out = cmp_out[0];
   assign cmp_out_b_out = cmp_out[1];
   assign cmp_out_a_en_out = chan_en[0];
   assign cmp_out_b_en_out = chan_en[1];
   assign irq_out = |(irq_stat & irq_mask);
endmodule : tcw_timer16

// ### testbench/tcw_timer16_asserts.sv
// Concurrent checks on the compare timer's register and pin behaviour
`timescale 1ns/10ps
module tcw_timer16_asserts (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic cmp_out_a_out,
   input wire logic cmp_out_a_en_out,
   input wire logic cmp_out_b_en_out,
   input wire logic irq_out
);
   import tcw_pkg::*;
   logic [7:0] shadow_a;
   logic [7:0] shadow_b;
   // Decoded bus events and the mode as software last set it
   wire wr_a = reg_wr_in && (reg_addr_in == OFS_CTRL_A);
   wire rd_a = reg_rd_in && (reg_addr_in == OFS_CTRL_A);
   wire frc_a = reg_wr_in && (reg_addr_in == OFS_CTRL_C) && reg_wdata_in[7];
   wire act_lo = shadow_a[6];
   wire [3:0] mode = {shadow_b[4:3], shadow_a[1:0]};
   // Force checks only with the counter stopped, so no real match interferes
   wire idle_norm = (mode == 4'h0) && (shadow_b[2:0] == 3'h0);
   wire idle_fast = (mode == 4'h5) && (shadow_b[2:0] == 3'h0);

   // Shadow copies of both control registers
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         shadow_a <= 8'h00;
         shadow_b <= 8'h00;
      end else begin
         if (wr_a)
            shadow_a <= reg_wdata_in;
         if (reg_wr_in && (reg_addr_in == OFS_CTRL_B))
            shadow_b <= reg_wdata_in;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   a_pin_takeover_a: assert property (wr_a |=>
      cmp_out_a_en_out == (($past(reg_wdata_in) & 8'hC0) != 8'h00))
      else $error("channel A pin takeover wrong");
   a_pin_takeover_b: assert property (wr_a |=>
      cmp_out_b_en_out == (($past(reg_wdata_in) & 8'h30) != 8'h00))
      else $error("channel B pin takeover wrong");
   a_takeover_holds: assert property (!wr_a |=> $stable(cmp_out_a_en_out))
      else $error("channel A takeover moved without a write");
   a_reserved_zero: assert property (rd_a |=> reg_rdata_out[3:2] == 2'h0)
      else $error("control A unused bits not zero");
   a_ctrl_readback: assert property (wr_a ##2 rd_a |=>
      reg_rdata_out == ($past(reg_wdata_in, 3) & CTRL_A_MASK))
      else $error("control A readback wrong");
   a_force_reads_zero: assert property (reg_rd_in &&
      reg_addr_in == OFS_CTRL_C |=> reg_rdata_out == 8'h00)
      else $error("force register read not zero");
   a_force_level: assert property (frc_a && idle_norm && shadow_a[7] |=>
      cmp_out_a_out == $past(act_lo))
      else $error("forced level wrong");
   a_force_toggle: assert property (frc_a && idle_norm &&
      shadow_a[7:6] == ACT_TOGGLE |=> cmp_out_a_out != $past(cmp_out_a_out))
      else $error("forced toggle missing");
   a_pwm_force_off: assert property (frc_a && idle_fast |=>
      $stable(cmp_out_a_out))
      else $error("force acted in a pwm mode");
   a_irq_masked: assert property (reg_wr_in && reg_addr_in == OFS_IRQ_MASK &&
      reg_wdata_in == 8'h00 |=> !irq_out)
      else $error("interrupt high with mask clear");
endmodule : tcw_timer16_asserts

bind tcw_timer16 tcw_timer16_asserts tcw_timer16_asserts_i (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .cmp_out_a_out(cmp_out_a_out),
   .cmp_out_a_en_out(cmp_out_a_en_out), .cmp_out_b_en_out(cmp_out_b_en_out),
   .irq_out(irq_out));

// ### testbench/tcw_timer16_bench.sv
// Self-checking bench for the compare timer
`timescale 1ns/10ps
module tcw_timer16_bench;
   import tcw_pkg::*;
   logic clk_sys_in, resetn_in, reg_wr_in, reg_rd_in, ext_tick_in;
   logic [7:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic [7:0] reg_rdata_out;
   logic out_a, out_b, en_a, en_b, irq;
   int errors;
   int n_tests;

   tcw_timer16 tcw_timer16_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .ext_tick_in(ext_tick_in),
      .cmp_out_a_out(out_a), .cmp_out_b_out(out_b),
      .cmp_out_a_en_out(en_a), .cmp_out_b_en_out(en_b), .irq_out(irq));

   // 100 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   task stop_test;
      $display("Checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk

   // A gap cycle after each write keeps one assignment per strobe per step
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1;
      chk(reg_rdata_out === exp, msg);
      @(posedge clk_sys_in);
   endtask : rd

   // Read one register and hand back the byte from the cycle after
   task peek(input logic [7:0] a, output logic [7:0] v);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1;
      v = reg_rdata_out;
      @(posedge clk_sys_in);
   endtask : peek

   // Strobes 80 cycles apart, so a free divide-by-8 gives exactly 10 ticks
   task t_presc;
      logic [7:0] v0;
      logic [7:0] v1;
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CTRL_B, 8'h02);
      peek(OFS_CNT_LO, v0);
      repeat (78) @(posedge clk_sys_in);
      peek(OFS_CNT_LO, v1);
      chk(8'(v1 - v0) == 8'h0A, "divide by 8 tick rate");
      wr(OFS_CTRL_B, 8'h00);
      peek(OFS_CNT_LO, v0);
      repeat (20) @(posedge clk_sys_in);
      peek(OFS_CNT_LO, v1);
      chk(v1 === v0, "stopped counter holds");
   endtask : t_presc

   // Load compare A while stopped in mode 0, run, count high cycles of A
   task duty(input logic [7:0] ca, input logic [7:0] cb,
      input logic [7:0] cmp, input int n, input int exp, input string msg);
      int hi;
      hi = 0;
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CMPA_LO, cmp);
      wr(OFS_CMPA_HI, 8'h00);
      wr(OFS_CTRL_A, ca);
      wr(OFS_CTRL_B, cb);
      repeat (700) @(posedge clk_sys_in);
      repeat (n) begin
         @(posedge clk_sys_in);
         #1;
         hi += (out_a === 1'b1);
      end
      chk(hi == exp, msg);
   endtask : duty

   task t_regs;
      rd(OFS_CTRL_A, 8'h00, "control A reset");
      wr(OFS_CTRL_A, 8'hFF);
      rd(OFS_CTRL_A, 8'hF3, "control A fields");
      chk(en_a === 1'b1 && en_b === 1'b1, "both pins taken");
      wr(OFS_CTRL_A, 8'h40);
      chk(en_a === 1'b1 && en_b === 1'b0, "only A taken");
      wr(OFS_CTRL_A, 8'h20);
      chk(en_a === 1'b0 && en_b === 1'b1, "only B taken");
      rd(8'h90, 8'h00, "unmapped read");
   endtask : t_regs

   task t_force;
      wr(OFS_CTRL_A, 8'hC0);
      wr(OFS_CTRL_C, 8'h80);
      chk(out_a === 1'b1, "force high");
      wr(OFS_CTRL_A, 8'h80);
      wr(OFS_CTRL_C, 8'h80);
      chk(out_a === 1'b0, "force low");
      wr(OFS_CTRL_A, 8'h40);
      wr(OFS_CTRL_C, 8'h80);
      chk(out_a === 1'b1, "force toggle up");
      wr(OFS_CTRL_C, 8'h80);
      chk(out_a === 1'b0, "force toggle down");
      rd(OFS_CTRL_C, 8'h00, "force reads zero");
      rd(OFS_IRQ_STAT, 8'h00, "force sets no flag");
      wr(OFS_CTRL_B, 8'h08);
      wr(OFS_CTRL_A, 8'h41);
      wr(OFS_CTRL_C, 8'h80);
      chk(out_a === 1'b0, "force ignored in fast pwm");
      wr(OFS_CTRL_A, 8'h30);
      wr(OFS_CTRL_C, 8'h40);
      chk(out_b === 1'b1, "force B high in ctc");
   endtask : t_force

   // Counter is still near zero here, so the small-TOP modes come first
   task t_toggle;
      duty(8'h43, 8'h19, 8'h0F, 32, 16, "fast toggle mode 15");
      duty(8'h43, 8'h11, 8'h0F, 60, 30, "dual toggle mode 11");
   endtask : t_toggle

   task t_fast;
      duty(8'h81, 8'h09, 8'h10, 256, 17, "fast non-inverting");
      duty(8'hC1, 8'h09, 8'h10, 256, 239, "fast inverting");
      duty(8'h81, 8'h09, 8'hFF, 256, 256, "fast compare at top");
   endtask : t_fast

   task t_dual;
      duty(8'h81, 8'h01, 8'h80, 510, 256, "dual non-inverting");
      duty(8'hC1, 8'h01, 8'h80, 510, 254, "dual inverting");
   endtask : t_dual

   task t_irq;
      wr(OFS_IRQ_MASK, 8'h00);
      chk(irq === 1'b0, "irq masked");
      wr(OFS_IRQ_MASK, 8'h01);
      chk(irq === 1'b1, "irq from wrap flag");
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_IRQ_STAT, 8'hFF);
      rd(OFS_IRQ_STAT, 8'h00, "status cleared");
      chk(irq === 1'b0, "irq dropped");
   endtask : t_irq

   // Main sequence
   initial begin
      errors = 0;
      n_tests = 0;
      resetn_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      ext_tick_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      repeat (2) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      @(posedge clk_sys_in);
      t_regs();
      t_force();
      t_toggle();
      t_fast();
      t_dual();
      t_irq();
      t_presc();
      stop_test();
   end

   // Watchdog well beyond the roughly 7000 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      errors++;
      stop_test();
   end
endmodule : tcw_timer16_bench
